// ==== tc_pkg.sv ====
package tc_pkg;

    // Register byte addresses (APB, one word each)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TMR_PARAM = 8'h04;
    localparam logic [7:0] ADDR_TMR_DATA0 = 8'h08;
    localparam logic [7:0] ADDR_TMR_DATA1 = 8'h0C;
    localparam logic [7:0] ADDR_TMR_DATA2 = 8'h10;
    localparam logic [7:0] ADDR_CNT_PARAM = 8'h14;
    localparam logic [7:0] ADDR_CNT_DATA0 = 8'h18;
    localparam logic [7:0] ADDR_CNT_DATA1 = 8'h1C;
    localparam logic [7:0] ADDR_CNT_DATA2 = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    // Control register bit positions
    localparam int CTRL_TMR_EN = 0;
    localparam int CTRL_CNT_IN = 1;
    localparam int CTRL_CNT_RST = 2;
    localparam int CTRL_EVAL = 3;

    // Status register bit positions
    localparam int ST_TMR_OUT = 0;
    localparam int ST_CNT_OUT = 1;
    localparam int ST_BASE_ERR = 2;

    // Time base codes
    localparam logic [7:0] TB_CODE_10MS = 8'h01;
    localparam logic [7:0] TB_CODE_100MS = 8'h0A;
    localparam logic [7:0] TB_CODE_1MS = 8'h64;

    // Clock and time bases
    localparam int CLK_HZ = 25_000_000;
    localparam int TB_1MS_US = 1000;
    localparam int TB_10MS_US = 10000;
    localparam int TB_100MS_US = 100000;
    localparam int TICK_1MS_CYC = CLK_HZ / 1_000_000 * TB_1MS_US;

    // Ranges
    localparam logic [15:0] VAL_MAX = 16'h7FFF;
    localparam logic [15:0] PRESET_NONE = 16'hFFFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [3:0] DIV10 = 4'h9;
    localparam logic [6:0] DIV100 = 7'h63;

    // Three-word operating structure
    typedef struct packed {
        logic [15:0] running_total;
        logic [15:0] target_value;
        logic [15:0] flags;
    } op_data_t;

    // APB request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// ==== off_delay_timer_and_up_counter.sv ====
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module off_delay_timer_and_up_counter
    import tc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_tmr_out,
    output logic o_cnt_out
);

    typedef struct packed {
        logic [3:0] ctrl;
        logic [7:0] tb_code;
        logic [15:0] tmr_preset;
        logic [15:0] cnt_preset;
        op_data_t tmr;
        op_data_t cnt;
        logic tmr_en_prev;
        logic cnt_in_prev;
        logic tmr_running;
        logic tmr_out;
        logic cnt_out;
        logic base_err;
        logic [14:0] pre_cnt;
        logic [3:0] div10_cnt;
        logic [6:0] div100_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Saturating add of one, range 0..32767
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v >= VAL_MAX) ? VAL_MAX : v + 16'h0001;
    endfunction

    // Preset -1 means take target from the structure
    function automatic logic [15:0] pick_target(input logic [15:0] p,
                                                input logic [15:0] stored);
        return (p == PRESET_NONE) ? stored : p;
    endfunction

    logic tick_1ms;
    logic tick_10ms;
    logic tick_100ms;
    logic base_tick;
    logic tb_valid;
    logic eval;
    logic tmr_en;
    logic cnt_in;
    logic cnt_rst;
    logic [15:0] tmr_target;
    logic [15:0] cnt_target;
    logic wr_acc;
    logic rd_acc;

    // Prescaler ticks derived from the running state
    always_comb begin
        tick_1ms = (state_reg.pre_cnt ==
                    15'(TICK_1MS_CYC - 1));
        tick_10ms = tick_1ms && (state_reg.div10_cnt == DIV10);
        // Both slow bases count whole 1 ms ticks, so phases stay aligned
        tick_100ms = tick_1ms && (state_reg.div100_cnt == DIV100);
    end

    // Base selection; bad codes freeze timing
    always_comb begin
        tb_valid = 1'b1;
        base_tick = 1'b0;
        case (state_reg.tb_code)
            TB_CODE_1MS: base_tick = tick_1ms;
            TB_CODE_10MS: base_tick = tick_10ms;
            TB_CODE_100MS: base_tick = tick_100ms;
            default: tb_valid = 1'b0;
        endcase
    end

    assign eval = state_reg.ctrl[CTRL_EVAL];
    assign tmr_en = state_reg.ctrl[CTRL_TMR_EN];
    assign cnt_in = state_reg.ctrl[CTRL_CNT_IN];
    assign cnt_rst = state_reg.ctrl[CTRL_CNT_RST];
    assign tmr_target = pick_target(state_reg.tmr_preset,
                                    state_reg.tmr.target_value);
    assign cnt_target = pick_target(state_reg.cnt_preset,
                                    state_reg.cnt.target_value);
    assign wr_acc = i_psel && i_penable && i_pwrite && !state_reg.pready;
    assign rd_acc = i_psel && i_penable && !i_pwrite && !state_reg.pready;

    // Next state: prescaler, timer, counter, bus
    always_comb begin
        state_next = state_reg;
        state_next.ctrl[CTRL_EVAL] = 1'b0;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;

        // Free-running prescaler, 1 ms base
        if (tick_1ms) begin
            state_next.pre_cnt = '0;
            state_next.div10_cnt = (state_reg.div10_cnt == DIV10) ?
                '0 : state_reg.div10_cnt + 4'h1;
            state_next.div100_cnt = (state_reg.div100_cnt == DIV100) ?
                '0 : state_reg.div100_cnt + 7'h01;
        end else begin
            state_next.pre_cnt = state_reg.pre_cnt + 15'h0001;
        end
        state_next.base_err = !tb_valid;

        // Off-delay timer; time accrues between evaluations
        if (tmr_en) begin
            state_next.tmr.running_total = ZERO16;
            state_next.tmr_running = 1'b0;
        end else if (state_reg.tmr_running && base_tick) begin
            state_next.tmr.running_total =
                sat_inc(state_reg.tmr.running_total);
        end
        if (eval) begin
            if (tmr_en) begin
                state_next.tmr_out = 1'b1;
            end else if (state_reg.tmr_en_prev) begin
                state_next.tmr_running = state_reg.tmr_out;
            end
            if (!tmr_en && state_reg.tmr_out &&
                state_reg.tmr.running_total >= tmr_target &&
                !state_reg.tmr_en_prev) begin
                state_next.tmr_out = 1'b0;
                state_next.tmr_running = 1'b0;
            end
            state_next.tmr_en_prev = tmr_en;
        end
        // Stop accruing at target even between evaluations
        if (!tmr_en && state_reg.tmr_running &&
            state_reg.tmr.running_total >= tmr_target) begin
            state_next.tmr_running = 1'b0;
            state_next.tmr.running_total = state_reg.tmr.running_total;
        end

        // Up counter, evaluated on scan strobe
        if (eval) begin
            if (cnt_rst) begin
                state_next.cnt.running_total = ZERO16;
                state_next.cnt_out = 1'b0;
            end else begin
                if (cnt_in && !state_reg.cnt_in_prev) begin
                    state_next.cnt.running_total =
                        sat_inc(state_reg.cnt.running_total);
                end
                state_next.cnt_out =
                    (state_next.cnt.running_total >= cnt_target);
            end
            state_next.cnt_in_prev = cnt_in;
        end

        // APB writes; timer/counter words mirror three-word structures
        if (wr_acc) begin
            case (i_paddr)
                ADDR_CTRL: state_next.ctrl = i_pwdata[3:0];
                ADDR_TMR_PARAM: begin
                    state_next.tb_code = i_pwdata[23:16];
                    state_next.tmr_preset = i_pwdata[15:0];
                end
                ADDR_TMR_DATA0: state_next.tmr.running_total =
                    i_pwdata[15:0];
                ADDR_TMR_DATA1: state_next.tmr.target_value =
                    i_pwdata[15:0];
                ADDR_TMR_DATA2: state_next.tmr.flags = i_pwdata[15:0];
                ADDR_CNT_PARAM: state_next.cnt_preset =
                    i_pwdata[15:0];
                ADDR_CNT_DATA0: state_next.cnt.running_total =
                    i_pwdata[15:0];
                ADDR_CNT_DATA1: state_next.cnt.target_value =
                    i_pwdata[15:0];
                ADDR_CNT_DATA2: state_next.cnt.flags = i_pwdata[15:0];
                ADDR_STATUS: ;
                default: state_next.pslverr = 1'b1;
            endcase
        end

        // APB reads, answered one cycle into the access phase
        state_next.prdata = 32'h0000_0000;
        if (rd_acc) begin
            case (i_paddr)
                ADDR_CTRL: state_next.prdata = {28'h0, state_reg.ctrl};
                ADDR_TMR_PARAM: state_next.prdata =
                    {8'h00, state_reg.tb_code, state_reg.tmr_preset};
                ADDR_TMR_DATA0: state_next.prdata =
                    {16'h0000, state_reg.tmr.running_total};
                ADDR_TMR_DATA1: state_next.prdata =
                    {16'h0000, state_reg.tmr.target_value};
                ADDR_TMR_DATA2: state_next.prdata =
                    {16'h0000, state_reg.tmr.flags};
                ADDR_CNT_PARAM: state_next.prdata =
                    {16'h0000, state_reg.cnt_preset};
                ADDR_CNT_DATA0: state_next.prdata =
                    {16'h0000, state_reg.cnt.running_total};
                ADDR_CNT_DATA1: state_next.prdata =
                    {16'h0000, state_reg.cnt.target_value};
                ADDR_CNT_DATA2: state_next.prdata =
                    {16'h0000, state_reg.cnt.flags};
                ADDR_STATUS: begin
                    state_next.prdata[ST_TMR_OUT] = state_reg.tmr_out;
                    state_next.prdata[ST_CNT_OUT] = state_reg.cnt_out;
                    state_next.prdata[ST_BASE_ERR] = state_reg.base_err;
                end
                default: state_next.pslverr = 1'b1;
            endcase
        end
        if (wr_acc || rd_acc) begin
            state_next.pready = 1'b1;
        end
    end

    // State register; counter total not auto-initialised beyond reset
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops
    assign o_prdata = state_reg.prdata;
    assign o_pready = state_reg.pready;
    assign o_pslverr = state_reg.pslverr;
    assign o_tmr_out = state_reg.tmr_out;
    assign o_cnt_out = state_reg.cnt_out;

endmodule // off_delay_timer_and_up_counter

// ==== ladder_master.sv ====
`timescale 1ns/100ps
module ladder_master
    import tc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    output apb_req_t o_req
);
    initial o_req = '0;

    // Request held until pready is sampled; only the bench timeout ends it
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge i_clk_sys);
        o_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge i_clk_sys);
        o_req.penable <= 1'b1;
        // Settled value mid-cycle is what the next rising edge samples
        do begin
            @(negedge i_clk_sys);
        end while (i_pready !== 1'b1);
        r = i_prdata;
        e = i_pslverr;
        @(posedge i_clk_sys);
        o_req <= '0;
    endtask
endmodule // ladder_master

// ==== odt_checker.sv ====
`timescale 1ns/100ps
module odt_checker
    import tc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_tmr_out,
    input wire logic o_cnt_out
);
    logic [2:0] since_reg;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    // Cycles since a scan strobe write; saturates so it never wraps
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            since_reg <= 3'h7;
        end else if (i_psel && i_penable && o_pready && i_pwrite
                     && i_paddr == ADDR_CTRL && i_pwdata[CTRL_EVAL]) begin
            since_reg <= 3'h0;
        end else if (since_reg != 3'h7) begin
            since_reg <= since_reg + 3'h1;
        end
    end

    chk_ready_due: assert property (
        i_psel && i_penable && !o_pready |=> o_pready) else $error("late");
    chk_ready_pulse: assert property (
        o_pready |=> !o_pready) else $error("pready held");
    chk_ready_cause: assert property (
        o_pready |-> $past(i_psel && i_penable)) else $error("stray");
    chk_err_ready: assert property (
        o_pslverr |-> o_pready) else $error("slverr alone");
    chk_err_unmapped: assert property (
        o_pready && i_paddr > ADDR_STATUS |-> o_pslverr) else $error("no err");
    chk_err_mapped: assert property (
        o_pready && !i_pwrite && i_paddr <= ADDR_STATUS
        && i_paddr[1:0] == 2'h0 |-> !o_pslverr) else $error("bad err");
    chk_outs_reset: assert property (
        $rose(i_resetn) |-> !o_tmr_out && !o_cnt_out) else $error("out set");
    chk_tmr_scan: assert property (
        $changed(o_tmr_out) |-> since_reg <= 3'h4) else $error("tmr moved");
    chk_cnt_scan: assert property (
        $changed(o_cnt_out) |-> since_reg <= 3'h4) else $error("cnt moved");
endmodule // odt_checker

bind off_delay_timer_and_up_counter odt_checker chk_u (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_tmr_out(o_tmr_out), .o_cnt_out(o_cnt_out));

// ==== off_delay_timer_and_up_counter_tb_top.sv ====
`timescale 1ns/100ps
module off_delay_timer_and_up_counter_tb_top
    import tc_pkg::*;
;
    logic clk;
    logic resetn;
    apb_req_t req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tmr_out;
    logic cnt_out;
    int n_mismatch = 0;
    int cmp_count = 0;

    off_delay_timer_and_up_counter uut (
        .i_clk_sys(clk), .i_resetn(resetn), .i_psel(req.psel),
        .i_penable(req.penable), .i_pwrite(req.pwrite),
        .i_paddr(req.paddr), .i_pwdata(req.pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_tmr_out(tmr_out),
        .o_cnt_out(cnt_out));
    ladder_master m (
        .i_clk_sys(clk), .i_pready(pready), .i_prdata(prdata),
        .i_pslverr(pslverr), .o_req(req));

    task automatic check(input string w, input logic [31:0] x,
                         input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", w, x, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        m.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] v;
        logic e;
        m.xfer(1'b0, a, 32'h0, v, e);
        check("word", x, {16'h0, v[15:0]});
    endtask
    // Scan strobe with the given enable, count and reset levels
    task automatic scan(input logic [2:0] b);
        wr(ADDR_CTRL, {28'h0, 1'b1, b});
    endtask
    task automatic st(input logic [2:0] k, input logic [2:0] x);
        logic [31:0] v;
        logic e;
        m.xfer(1'b0, ADDR_STATUS, 32'h0, v, e);
        check("status", {29'h0, x}, {29'h0, v[2:0] & k});
    endtask

    task automatic t_reset();
        logic [31:0] v;
        logic e;
        st(3'h3, 3'h0);
        rc(ADDR_CNT_DATA0, 32'h0);
        m.xfer(1'b0, 8'h40, 32'h0, v, e);
        check("slverr", 32'h1, {31'h0, e});
        $display("test reset done");
    endtask
    task automatic t_count();
        wr(ADDR_CNT_PARAM, 32'h3);
        scan(3'h2);
        scan(3'h2);
        rc(ADDR_CNT_DATA0, 32'h1);
        scan(3'h0);
        scan(3'h2);
        rc(ADDR_CNT_DATA0, 32'h2);
        st(3'h2, 3'h0);
        wr(ADDR_CNT_PARAM, 32'h1);
        scan(3'h0);
        st(3'h2, 3'h2);
        check("cnt_out", 32'h1, {31'h0, cnt_out});
        scan(3'h6);
        rc(ADDR_CNT_DATA0, 32'h0);
        st(3'h2, 3'h0);
        scan(3'h0);
        wr(ADDR_CNT_PARAM, 32'hFFFF);
        wr(ADDR_CNT_DATA1, 32'h7FFF);
        wr(ADDR_CNT_DATA0, 32'h7FFE);
        scan(3'h2);
        st(3'h2, 3'h2);
        scan(3'h0);
        scan(3'h2);
        rc(ADDR_CNT_DATA0, 32'h7FFF);
        $display("test counter done");
    endtask
    task automatic t_timer();
        logic [31:0] v;
        logic e;
        logic [7:0] cd [5] = '{TB_CODE_10MS, TB_CODE_100MS, 8'h02, 8'h00,
                               TB_CODE_1MS};
        logic [2:0] be [5] = '{3'h0, 3'h0, 3'h4, 3'h4, 3'h0};
        foreach (cd[i]) begin
            wr(ADDR_TMR_PARAM, {8'h0, cd[i], 16'h1});
            scan(3'h1);
            st(3'h5, 3'h1 | be[i]);
        end
        rc(ADDR_TMR_DATA0, 32'h0);
        scan(3'h0);
        st(3'h1, 3'h1);
        repeat (TICK_1MS_CYC) @(posedge clk);
        scan(3'h0);
        st(3'h1, 3'h0);
        m.xfer(1'b0, ADDR_TMR_DATA0, 32'h0, v, e);
        check("total", 32'h1, {31'h0, v[15:0] inside {16'h1, 16'h2}});
        repeat (TICK_1MS_CYC) @(posedge clk);
        rc(ADDR_TMR_DATA0, {16'h0, v[15:0]});
        scan(3'h1);
        st(3'h1, 3'h1);
        check("tmr_out", 32'h1, {31'h0, tmr_out});
        rc(ADDR_TMR_DATA0, 32'h0);
        $display("test timer done");
    endtask

    task automatic summarize();
        $display("compared %0d mismatched %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Run needs about 50k cycles; generous margin before giving up
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        resetn = 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_count();
        t_timer();
        summarize();
    end
endmodule // off_delay_timer_and_up_counter_tb_top
